// file: rtl/udfs_pkg.sv
// Package of offsets, fields and reset values for the USB device frame and state registers.
package udfs_pkg;
   localparam logic [7:0] OFS_FRAME = 8'h00;
   localparam logic [7:0] OFS_GLB = 8'h04;
   localparam logic [7:0] OFS_FADDR = 8'h08;
   localparam logic [7:0] OFS_IER = 8'h10;
   localparam logic [7:0] OFS_IDR = 8'h14;
   localparam logic [7:0] OFS_IMR = 8'h18;
   localparam logic [7:0] OFS_ISR = 8'h1c;
   localparam logic [7:0] OFS_ICR = 8'h20;
   localparam logic [7:0] OFS_RST_EP = 8'h28;
   localparam logic [7:0] OFS_CSR = 8'h30;
   localparam logic [7:0] OFS_FDR = 8'h50;
   localparam logic [7:0] OFS_TXVC = 8'h74;
   localparam int NUM_EP = 6;
   localparam int FRAME_W = 11;
   localparam int BIT_SOF_ERR = 16;
   localparam int BIT_SOF_OK = 17;
   localparam int BIT_ADDR = 0;
   localparam int BIT_CONF = 1;
   localparam int BIT_RSM = 3;
   localparam int BIT_SOFINT = 11;
   localparam int BIT_FEN = 8;
   localparam int NARROW_OK_BIT = 4;
   localparam int NARROW_ERR_BIT = 3;
   localparam logic [31:0] FADDR_RESET = 32'h0000_0100;
   localparam logic [31:0] IMR_RESET = 32'h0000_1200;
   localparam logic [31:0] IRQ_FIELDS = 32'h0000_2f3f;
   localparam logic [31:0] IMR_FORCED = 32'h0000_1000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : udfs_pkg

// file: rtl/udfs_regs.sv
// USB device port register slave: frame number, device state, interrupts, endpoints.
`timescale 1ns/1ns
// Operation
// - Each endpoint has a control and status register at 0x030 plus four per endpoint, zero at reset.
// - Each endpoint has a read-write FIFO data register at 0x050 plus four per endpoint.
// - The 11-bit frame count from the host is loaded at the end of each start-of-frame packet.
// - Bit 16 flags a bad start-of-frame packet at its end and clears on the next frame PID.
// - Bit 17 flags a good start-of-frame packet at its end and clears on the next frame PID.
// - The start-of-frame interrupt status rises as soon as the frame PID arrives.
// - In the byte-wide view the good flag is bit 4 of the high byte, the error flag bit 3 of the low.
// - Bit 0 of the state register shows address state; writing 1 sets it, only reset clears it.
// - Bit 1 of the state register shows configured state, written 1 to enter and 0 to leave.
// - Bit 3 of the state register reads 1 while the remote-resume request input is high.
// - The interrupt status has no promised reset value, so tests must not rely on one.
// - The 7-bit function address is zero after any reset.
module udfs_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sof_pid,
   input wire logic sof_eop,
   input wire logic sof_crc_error,
   input wire logic [udfs_pkg::FRAME_W-1:0] sof_frame_count,
   input wire logic [udfs_pkg::NUM_EP-1:0] ep_event,
   input wire logic [4:0] bus_event,
   input wire logic resume_request_pending,
   output logic [7:0] frame_count_high_byte,
   output logic [7:0] frame_count_low_byte,
   output logic [6:0] function_address_value,
   output logic function_enable,
   output logic address_state_bit,
   output logic configured_state_bit,
   output logic irq
);
   import udfs_pkg::*;

   // ****************************************
   // Bus write channel.
   // ****************************************
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic wr_go;
   logic [31:0] wmask;
   logic [31:0] wval;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_go = aw_held && w_held;
   assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   assign wval = w_data & wmask;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held <= 1'b0;
      end
   end

   function automatic logic [1:0] addr_resp(input logic [7:0] a);
      logic known;
      known = (a[1:0] == 2'b00) && (a != 8'h0c) && (a != 8'h24) && (a != 8'h2c) &&
              (a != 8'h70) && (a < 8'h78) && !(a >= 8'h48 && a < 8'h50) &&
              !(a >= 8'h68 && a < 8'h70);
      addr_resp = known ? RESP_OKAY : RESP_OKAY;
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_resp(aw_addr);
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // Frame number and flags.
   // ****************************************
   logic [FRAME_W-1:0] frame_count;
   logic sof_good_flag;
   logic sof_error_flag;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_count <= '0;
         sof_good_flag <= 1'b0;
         sof_error_flag <= 1'b0;
      end else if (sof_eop) begin
         frame_count <= sof_frame_count;
         sof_error_flag <= sof_crc_error;
         sof_good_flag <= !sof_crc_error;
      end else if (sof_pid) begin
         sof_error_flag <= 1'b0;
         sof_good_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_count_high_byte <= 8'h00;
         frame_count_low_byte <= 8'h00;
      end else begin
         frame_count_high_byte <= {3'b000, sof_good_flag, 1'b0, frame_count[10:8]};
         frame_count_low_byte <= frame_count[7:0];
         frame_count_low_byte[NARROW_ERR_BIT] <= sof_error_flag;
      end
   end

   // ****************************************
   // Device state and function address.
   // ****************************************
   logic wr_glb;
   logic wr_faddr;

   assign wr_glb = wr_go && aw_addr == OFS_GLB && w_strb[0];
   assign wr_faddr = wr_go && aw_addr == OFS_FADDR;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         address_state_bit <= 1'b0;
         configured_state_bit <= 1'b0;
      end else if (wr_glb) begin
         if (w_data[BIT_ADDR]) begin
            address_state_bit <= 1'b1;
         end
         configured_state_bit <= w_data[BIT_CONF];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         function_address_value <= 7'h00;
         function_enable <= FADDR_RESET[BIT_FEN];
      end else if (wr_faddr) begin
         if (w_strb[0]) begin
            function_address_value <= w_data[6:0];
         end
         if (w_strb[1]) begin
            function_enable <= w_data[BIT_FEN];
         end
      end
   end

   // ****************************************
   // Interrupt status and mask.
   // ****************************************
   logic [31:0] irq_status;
   logic [31:0] irq_mask;
   logic [31:0] irq_set;
   logic wr_icr;

   assign irq_set = {18'h0, bus_event[4], 1'b0, sof_pid, bus_event[2:0], 2'b00, ep_event} |
                    {19'h0, bus_event[3], 12'h000};
   assign wr_icr = wr_go && aw_addr == OFS_ICR;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= 32'h0000_0000;
      end else begin
         // A new event in the clearing cycle stays set.
         irq_status <= ((irq_status & ~(wr_icr ? wval : 32'h0000_0000)) | irq_set) &
                       (IRQ_FIELDS | IMR_FORCED);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= IMR_RESET;
      end else if (wr_go && aw_addr == OFS_IER) begin
         irq_mask <= (irq_mask | wval) & IRQ_FIELDS | IMR_FORCED;
      end else if (wr_go && aw_addr == OFS_IDR) begin
         irq_mask <= (irq_mask & ~wval) & IRQ_FIELDS | IMR_FORCED;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ****************************************
   // Endpoint and transceiver registers.
   // ****************************************
   logic [31:0] ep_csr [NUM_EP];
   logic [31:0] ep_fdr [NUM_EP];
   logic [31:0] rst_ep;
   logic [31:0] txvc;

   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++) begin : g_ep
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ep_csr[g] <= 32'h0000_0000;
               ep_fdr[g] <= 32'h0000_0000;
            end else if (wr_go) begin
               if (aw_addr == OFS_CSR + 8'(4 * g)) begin
                  ep_csr[g] <= (ep_csr[g] & ~wmask) | wval;
               end
               if (aw_addr == OFS_FDR + 8'(4 * g)) begin
                  ep_fdr[g] <= (ep_fdr[g] & ~wmask) | wval;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_ep <= 32'h0000_0000;
         txvc <= 32'h0000_0000;
      end else if (wr_go) begin
         if (aw_addr == OFS_RST_EP) begin
            rst_ep <= (rst_ep & ~wmask) | wval;
         end
         if (aw_addr == OFS_TXVC) begin
            txvc <= (txvc & ~wmask) | wval;
         end
      end
   end

   // ****************************************
   // Read channel.
   // ****************************************
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         OFS_FRAME: rd_mux = {14'h0, sof_good_flag, sof_error_flag, 5'h00, frame_count};
         OFS_GLB: rd_mux = {28'h0, resume_request_pending, 1'b0, configured_state_bit,
                            address_state_bit};
         OFS_FADDR: rd_mux = {23'h0, function_enable, 1'b0, function_address_value};
         OFS_IMR: rd_mux = irq_mask;
         OFS_ISR: rd_mux = irq_status;
         OFS_RST_EP: rd_mux = rst_ep;
         OFS_TXVC: rd_mux = txvc;
         default: begin
            for (int i = 0; i < NUM_EP; i++) begin
               if (s_axi_araddr == OFS_CSR + 8'(4 * i)) begin
                  rd_mux = ep_csr[i];
               end
               if (s_axi_araddr == OFS_FDR + 8'(4 * i)) begin
                  rd_mux = ep_fdr[i];
               end
            end
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // Checks.
   // ****************************************
   sequence sof_end_s;
      sof_eop;
   endsequence

   frame_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      sof_end_s |=> frame_count == $past(sof_frame_count))
      else $error("frame count not loaded");
   sof_err_a: assert property (@(posedge clk) disable iff (!rst_n)
      sof_end_s |=> sof_error_flag == $past(sof_crc_error))
      else $error("frame error flag wrong");
   sof_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
      (sof_pid && !sof_eop) |=> !sof_good_flag && !sof_error_flag)
      else $error("frame flags not cleared");
   sof_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
      sof_pid |=> irq_status[BIT_SOFINT])
      else $error("sof status not raised");
   narrow_view_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 frame_count_high_byte[NARROW_OK_BIT] == $past(sof_good_flag))
      else $error("byte view wrong");
   addr_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      address_state_bit |=> address_state_bit)
      else $error("address state left");
   conf_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_glb |=> configured_state_bit == $past(w_data[BIT_CONF]))
      else $error("configured state wrong");
   resume_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_GLB) |=>
      s_axi_rdata[BIT_RSM] == $past(resume_request_pending))
      else $error("resume bit wrong");

   sequence glb_read_s;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_GLB;
   endsequence

   frame_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sof_eop |=> $stable(frame_count))
      else $error("frame count moved without a packet end");
   sof_good_a: assert property (@(posedge clk) disable iff (!rst_n)
      sof_end_s |=> sof_good_flag == !$past(sof_crc_error))
      else $error("frame good flag wrong");
   low_view_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 frame_count_low_byte[NARROW_ERR_BIT] == $past(sof_error_flag))
      else $error("low byte view wrong");
   sof_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      (irq_status[BIT_SOFINT] && !(wr_icr && wval[BIT_SOFINT])) |=> irq_status[BIT_SOFINT])
      else $error("sof status lost");
   addr_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_glb && w_data[BIT_ADDR]) |=> address_state_bit)
      else $error("address state not entered");
   glb_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      glb_read_s |=> s_axi_rdata[BIT_ADDR] == $past(address_state_bit))
      else $error("address state bit read wrong");
   faddr_reset_a: assert property (@(posedge clk)
      $rose(rst_n) |-> function_address_value == 7'h00)
      else $error("function address not cleared by reset");
   csr_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_go && aw_addr == OFS_CSR && w_strb == 4'hf) |=> ep_csr[0] == $past(w_data))
      else $error("endpoint control word not written");
   fdr_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_go && aw_addr == OFS_FDR && w_strb == 4'hf) |=> ep_fdr[0] == $past(w_data))
      else $error("endpoint data word not written");
   rsv_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h78) |=>
      s_axi_rdata == 32'h0000_0000)
      else $error("reserved offset read not zero");
   bresp_okay_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_axi_bvalid |-> s_axi_bresp == RESP_OKAY)
      else $error("write response not okay");
endmodule // udfs_regs

// file: dv/udfs_host_model.sv
// Behavioural host that sends start-of-frame packets.
`timescale 1ns/1ns
module udfs_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [udfs_pkg::FRAME_W-1:0] frame,
   input wire logic bad,
   input wire logic [7:0] gap,
   output logic busy,
   output logic sof_pid,
   output logic sof_eop,
   output logic sof_crc_error,
   output logic [udfs_pkg::FRAME_W-1:0] sof_frame_count
);
   logic [7:0] cnt;
   // Outside the end of packet the frame and error lines carry a changing pattern.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         sof_pid <= 1'b0;
         sof_eop <= 1'b0;
         sof_crc_error <= 1'b0;
         sof_frame_count <= '0;
      end else begin
         sof_pid <= go & ~busy;
         sof_eop <= 1'b0;
         sof_crc_error <= ~sof_crc_error;
         sof_frame_count <= ~sof_frame_count;
         if (go && !busy) begin
            busy <= 1'b1;
            cnt <= gap;
         end else if (busy && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end else if (busy) begin
            busy <= 1'b0;
            sof_eop <= 1'b1;
            sof_crc_error <= bad;
            sof_frame_count <= frame;
         end
      end
   end
endmodule // udfs_host_model

// file: dv/usb_device_frame_and_state_regs_tb_top.sv
// Self-checking bench for the USB device frame and state registers.
`timescale 1ns/1ns
module usb_device_frame_and_state_regs_tb_top;
   import udfs_pkg::*;
   localparam logic [7:0] RSV [6] = '{8'h0c, 8'h24, 8'h2c, 8'h70, 8'h78, 8'hfc};
   localparam logic [31:0] GLB_W [4] = '{32'h1, 32'h3, 32'h0, 32'h2};
   localparam logic [31:0] GLB_E [4] = '{32'h1, 32'h3, 32'h1, 32'h3};
   localparam int SRC [11] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 12, 13};
   logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, h_gap, frame_count_high_byte, frame_count_low_byte;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic sof_pid, sof_eop, sof_crc_error, h_go, h_bad, h_busy, resume_request_pending, irq;
   logic function_enable, address_state_bit, configured_state_bit;
   logic [FRAME_W-1:0] sof_frame_count, h_frame;
   logic [NUM_EP-1:0] ep_event;
   logic [4:0] bus_event;
   logic [6:0] function_address_value;
   logic [31:0] exp_q [$];
   int n_mismatch = 0;
   int n_compared = 0;
   udfs_host_model u_host (.clk, .rst_n, .go(h_go), .frame(h_frame), .bad(h_bad), .gap(h_gap),
      .busy(h_busy), .sof_pid, .sof_eop, .sof_crc_error, .sof_frame_count);
   udfs_regs u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .sof_pid, .sof_eop, .sof_crc_error, .sof_frame_count, .ep_event, .bus_event,
      .resume_request_pending, .frame_count_high_byte, .frame_count_low_byte,
      .function_address_value, .function_enable, .address_state_bit, .configured_state_bit, .irq);
   // ********************************
   // Tasks
   // ********************************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         n_mismatch++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      check(32'(s_axi_bresp), 32'(RESP_OKAY));
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
   endtask
   task automatic sof_start(input logic [FRAME_W-1:0] f, input logic b, input logic [7:0] g);
      h_frame <= f;
      h_bad <= b;
      h_gap <= g;
      h_go <= 1'b1;
      @(posedge clk);
      h_go <= 1'b0;
   endtask
   task automatic sof_end(input logic [FRAME_W-1:0] f, input logic b);
      do @(posedge clk); while (h_busy !== 1'b0);
      axi_rd(OFS_FRAME, {14'h0, ~b, b, 5'h0, f});
      check(32'(frame_count_high_byte[NARROW_OK_BIT]), {31'h0, !b});
      check(32'(frame_count_low_byte[NARROW_ERR_BIT]), 32'(b));
   endtask
   // ********************************
   // Clock, checker and sequence
   // ********************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         check(s_axi_rdata, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
   initial begin
      logic [7:0] ofs [$];
      logic [31:0] val [$];
      logic [31:0] d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, h_go, h_bad, resume_request_pending} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, h_frame, h_gap, ep_event, bus_event} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
      rst_n = 1'b0;
      void'($urandom(85848));
      repeat (5) @(posedge clk);
      // Registers are touched only after reset, with the port clock running.
      rst_n <= 1'b1;
      axi_rd(OFS_FRAME, 32'h0);
      axi_rd(OFS_GLB, 32'h0);
      axi_rd(OFS_FADDR, FADDR_RESET);
      axi_rd(OFS_IMR, IMR_RESET);
      ofs = '{OFS_RST_EP, OFS_TXVC};
      for (int i = 0; i < NUM_EP; i++) begin
         ofs.push_back(8'(OFS_CSR + 4 * i));
         ofs.push_back(8'(OFS_FDR + 4 * i));
      end
      foreach (ofs[k]) begin
         axi_rd(ofs[k], 32'h0);
         val.push_back($urandom);
         axi_wr(ofs[k], val[k]);
      end
      foreach (RSV[k]) axi_wr(RSV[k], $urandom);
      foreach (ofs[k]) axi_rd(ofs[k], val[k]);
      foreach (RSV[k]) axi_rd(RSV[k], 32'h0);
      axi_wr(OFS_FADDR, 32'hffff_ffff);
      axi_rd(OFS_FADDR, 32'h17f);
      for (int i = 0; i < 4; i++) begin
         axi_wr(OFS_GLB, GLB_W[i]);
         axi_rd(OFS_GLB, GLB_E[i]);
      end
      resume_request_pending <= 1'b1;
      axi_rd(OFS_GLB, 32'hb);
      check({30'h0, configured_state_bit, address_state_bit}, 32'h3);
      axi_wr(OFS_FADDR, 32'h23);
      check({24'h0, function_enable, function_address_value}, 32'h23);
      axi_wr(OFS_IDR, IRQ_FIELDS);
      axi_wr(OFS_ICR, IRQ_FIELDS);
      axi_rd(OFS_IMR, IMR_FORCED);
      axi_rd(OFS_ISR, 32'h0);
      d = $urandom;
      sof_start(d[10:0], 1'b0, 8'h00);
      sof_end(d[10:0], 1'b0);
      axi_wr(OFS_ICR, 32'h800);
      axi_wr(OFS_IER, 32'h800);
      axi_rd(OFS_IMR, 32'h1800);
      check(32'(irq), 32'h0);
      sof_start(11'h5a3, 1'b1, 8'h28);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h1);
      axi_rd(OFS_ISR, 32'h800);
      axi_rd(OFS_FRAME, {21'h0, d[10:0]});
      sof_end(11'h5a3, 1'b1);
      axi_wr(OFS_ICR, 32'h800);
      check(32'(irq), 32'h0);
      axi_wr(OFS_IDR, IRQ_FIELDS);
      foreach (SRC[k]) begin
         if (k < NUM_EP) ep_event <= 6'(1 << k);
         else bus_event <= 5'(1 << (k - NUM_EP));
         @(posedge clk);
         {ep_event, bus_event} <= '0;
         axi_rd(OFS_ISR, 32'h1 << SRC[k]);
         check(32'(irq), 32'(SRC[k] == 12));
         axi_wr(OFS_IER, 32'h1 << SRC[k]);
         check(32'(irq), 32'h1);
         axi_wr(OFS_IDR, 32'h1 << SRC[k]);
         check(32'(irq), 32'(SRC[k] == 12));
         axi_wr(OFS_ICR, 32'h1 << SRC[k]);
         check(32'(irq), 32'h0);
      end
      final_report();
   end
endmodule // usb_device_frame_and_state_regs_tb_top
